// ### host_serial_datagram_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module host_serial_datagram_port_test;
    import hsdp_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic irq_n_in = 1'b1;
    logic ld = 1'b0;
    logic [3:0] pd = 4'h0;
    logic [31:0] rw = 32'h0000_0000;
    logic [31:0] rx;
    logic [31:0] w;
    logic [32:0] nt;
    logic [32:0] notes[$];
    wire sel, sck, sdi, pin, oe, vld, rd, err;
    wire [31:0] hw;
    wire [3:0] psc;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 32'h0000_92eb;
    hsdp_port dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .host_select_n_in(sel),
        .host_serial_clock_in(sck), .host_serial_in(sdi), .serial_out_irq_pin_out(pin),
        .serial_out_irq_pin_oe_out(oe), .irq_n_in(irq_n_in), .read_word_in(rw), .prescaler_load_in(ld),
        .prescaler_data_in(pd), .hold_word_out(hw), .hold_valid_out(vld), .hold_is_read_out(rd),
        .frame_error_out(err), .step_clock_prescaler_out(psc));
    hsdp_host_model host (.clk_in(clk_in), .sel_n_out(sel), .sck_out(sck), .sdi_out(sdi), .sdo_in(pin));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, well above the ~1850 cycles the sequence needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    // results are one-cycle pulses, read mid-cycle once settled
    always @(negedge clk_in) begin
        if (vld === 1'b1 || err === 1'b1) begin
            nt = notes.pop_front();
            `CHK({err, hw}, nt)
            if (!nt[32]) `CHK(rd, nt[RW_POS])
        end
    end
    initial begin
        repeat (3) @(negedge clk_in);
        `CHK(psc, PRESC_RST)
        `CHK({hw, vld, err}, {WORD_RST, 2'b00})
        arst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        `CHK(oe, 1'b1)
        for (int i = 0; i < 6; i++) begin
            w = $random(seed);
            w[RW_POS] = i[0];
            rw = $random(seed);
            irq_n_in = i[1];
            notes.push_back({1'b0, w});
            host.xfer(w, 32, rx);
            `CHK(rx, rw)
            `CHK(pin, irq_n_in)
        end
        // a short frame must be dropped and flagged, leaving the last word
        notes.push_back({1'b1, w});
        host.xfer($random(seed), 31, rx);
        pd = 4'h5;
        ld = 1'b1;
        @(negedge clk_in);
        ld = 1'b0;
        @(negedge clk_in);
        `CHK(psc, 4'h5)
        `CHK(notes.size() == 0, 1'b1)
        wrap_up();
    end
endmodule
bind hsdp_port hsdp_port_properties chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .host_select_n_in(host_select_n_in), .host_serial_clock_in(host_serial_clock_in),
    .serial_out_irq_pin_out(serial_out_irq_pin_out), .serial_out_irq_pin_oe_out(serial_out_irq_pin_oe_out),
    .irq_n_in(irq_n_in), .prescaler_load_in(prescaler_load_in), .prescaler_data_in(prescaler_data_in),
    .hold_word_out(hold_word_out), .hold_valid_out(hold_valid_out), .hold_is_read_out(hold_is_read_out),
    .frame_error_out(frame_error_out), .step_clock_prescaler_out(step_clock_prescaler_out));
`default_nettype wire

// ### hsdp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsdp_host_model (
    // timing reference
    input wire logic clk_in,
    // serial pins toward the device
    output logic sel_n_out,
    output logic sck_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    // idle: select and clock high, link clock stands still
    initial begin
        sel_n_out = 1'b1;
        sck_out = 1'b1;
        sdi_out = 1'b0;
    end
    // phases of 4 clocks, since the device needs 3 and syncs with 3-clock latency
    task automatic ph;
        repeat (4) @(negedge clk_in);
    endtask
    // one frame of n bits, MSB first; read-back sampled on each rising clock
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
        rx = 32'h0000_0000;
        sel_n_out = 1'b0;
        ph();
        for (int i = 0; i < n; i++) begin
            sck_out = 1'b0;
            sdi_out = w[31-i];
            ph();
            sck_out = 1'b1;
            rx = {rx[30:0], sdo_in};
            ph();
        end
        sel_n_out = 1'b1;
        sdi_out = ~sdi_out; // released line flips so a stale bit never looks valid
        ph();
    endtask
endmodule
`default_nettype wire

// ### hsdp_pins_if.sv
`timescale 1ns/1ps
`default_nettype none
// synchronised serial pins: current agreed level and level one cycle earlier
interface hsdp_pins_if;
    logic [hsdp_pkg::PIN_N-1:0] level;
    logic [hsdp_pkg::PIN_N-1:0] prior;
    modport sync (output level, output prior);
    modport core (input level, input prior);
endinterface
`default_nettype wire

// ### hsdp_pkg.sv
package hsdp_pkg;
    // datagram geometry
    localparam int unsigned DGRAM_BITS = 32;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] DGRAM_CNT = 6'h20;
    // field positions inside a received datagram
    localparam int unsigned RRS_POS = 31;
    localparam int unsigned ADDR_HI = 30;
    localparam int unsigned ADDR_LO = 24;
    localparam int unsigned RW_POS = 23;
    localparam logic RW_READ = 1'b1;
    // reset values
    localparam int unsigned PRESC_W = 4;
    localparam logic [PRESC_W-1:0] PRESC_RST = 4'hF;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // synchroniser depth and output timing
    localparam int unsigned SYNC_STAGES = 3;
    localparam int unsigned SDO_VALID_CYC = 4;
    // index of the synchronised pins
    localparam int unsigned PIN_SEL = 0;
    localparam int unsigned PIN_SCK = 1;
    localparam int unsigned PIN_SDI = 2;
    localparam int unsigned PIN_N = 3;
endpackage

// ### hsdp_port.sv
// Function
// RL1: state is set only by the internal power-on reset; no reset pin.
// RL2: host waits for reset release and a stable clock before any access.
// RL3: reset clears every bit to zero, prescaler field loads fifteen; the code also resets the pin level and its enable to one.
// RL4: with select high the output pin carries the active-low interrupt.
// RL5: serial output pin is always driven, never high impedance.
// RL6: every transfer is exactly one 32-bit datagram in each direction.
// RL7: receive path is a 32-bit shift register fed from serial input.
// RL8: one input bit shifts in on every rising serial clock edge.
// RL9: select rising edge copies the shift register into a holding buffer.
// RL10: during reception the read-back word shifts out on the output.
// RL11: host samples the serial output on rising serial clock edges.
// RL12: output bit updates after each falling clock, valid within four cycles.
// RL13: host is sole master; device never starts a datagram itself.
// RL14: datagrams travel most significant bit first in both directions.
// RL15: host holds serial clock low and high at least three cycles each.
// RL16: select high three cycles before a transfer, three before first clock.
// RL17: read_write_select bit is one for read, zero for write.
// RL18: select, clock and data are synchronised and edge-detected on clk.
// RL19: read-back word loads on select fall so first bit precedes clocking.
`timescale 1ns/1ps
`default_nettype none
module hsdp_port
    import hsdp_pkg::*;
(
    // system clock and power-on reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // serial pins from the host
    input wire logic host_select_n_in,
    input wire logic host_serial_clock_in,
    input wire logic host_serial_in,
    // combined data / interrupt pin
    output logic serial_out_irq_pin_out,
    output logic serial_out_irq_pin_oe_out,
    // internal side
    input wire logic irq_n_in,
    input wire logic [DGRAM_BITS-1:0] read_word_in,
    input wire logic prescaler_load_in,
    input wire logic [PRESC_W-1:0] prescaler_data_in,
    // executed datagram
    output logic [DGRAM_BITS-1:0] hold_word_out,
    output logic hold_valid_out,
    output logic hold_is_read_out,
    output logic frame_error_out,
    output logic [PRESC_W-1:0] step_clock_prescaler_out
);
    // register state of the port, all in one packed word:
    //   rx and tx are the receive and read-back shifters, cnt counts rising clocks,
    //   hold, valid, is_read and err form the executed-datagram side,
    //   presc is the step clock prescaler field
    typedef struct packed {
        logic [DGRAM_BITS-1:0] rx;
        logic [DGRAM_BITS-1:0] tx;
        logic [CNT_W-1:0] cnt;
        logic active;
        logic sdo;
        logic oe;
        logic [DGRAM_BITS-1:0] hold;
        logic valid;
        logic is_read;
        logic err;
        logic [PRESC_W-1:0] presc;
    } hsdp_port_s;

    hsdp_port_s st_r;
    hsdp_port_s st_nxt;

    // timing at a glance, in system clocks after a host pin change:
    //   the crossing needs three flops and an agreed level before an edge counts,
    //   so state reacts at the fourth rising clock after the pin moved.
    //   select fall -> read-back msb on the pin four clocks later
    //   clock fall  -> next read-back bit on the pin four clocks later
    //   clock rise  -> input bit enters the receive shifter four clocks later
    //   select rise -> result pulse and interrupt level four clocks later
    // the host keeps each phase at least three clocks long, so edges never overlap
    // inside the crossing; shorter phases are outside what the port serves.
    // limitation: edges are only seen while the system clock runs; with the
    // clock stopped the port is deaf and the pin keeps its last level.
    // the receive counter saturates at the datagram length, so a long frame keeps
    // its last bits and is executed; a short one is flagged and dropped.

    // parameter sanity: the fixed package values must fit the logic below
    initial begin
        if (DGRAM_BITS < 2) begin
            $error("hsdp_port: datagram too short for the shifters");
        end
        if (DGRAM_CNT != CNT_W'(DGRAM_BITS)) begin
            $error("hsdp_port: counter end value differs from the datagram length");
        end
        if ((64'd1 << CNT_W) <= 64'(DGRAM_BITS)) begin
            $error("hsdp_port: bit counter too narrow to reach the datagram length");
        end
        if (RW_POS >= DGRAM_BITS || RRS_POS >= DGRAM_BITS) begin
            $error("hsdp_port: control bit positions lie outside the datagram");
        end
        if (ADDR_LO > ADDR_HI || ADDR_HI >= DGRAM_BITS) begin
            $error("hsdp_port: address field lies outside the datagram");
        end
        if (SYNC_STAGES != 3) begin
            $error("hsdp_port: edge timing assumes a three-stage crossing");
        end
        if (PRESC_W < 4) begin
            $error("hsdp_port: prescaler field cannot hold its reset value");
        end
    end

    hsdp_pins_if pins ();

    // three-flop crossing of the host pins; data rides in the same crossing as
    // the clock so a sampled bit is always as old as the edge that takes it
    hsdp_sync #(
        .WIDTH(PIN_N)
    ) u_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .pins_in({host_serial_in, host_serial_clock_in, host_select_n_in}),
        .pins(pins)
    );

    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;
    logic sdi_bit;

    // edges are judged on the agreed level against its registered copy;
    // the data bit is read from the agreed level, never from the first stage
    always_comb begin
        sel_fall = pins.prior[PIN_SEL] & ~pins.level[PIN_SEL]; // RL18
        sel_rise = ~pins.prior[PIN_SEL] & pins.level[PIN_SEL];
        sck_rise = ~pins.prior[PIN_SCK] & pins.level[PIN_SCK];
        sck_fall = pins.prior[PIN_SCK] & ~pins.level[PIN_SCK];
        sdi_bit = pins.level[PIN_SDI];
    end

    // datagram engine; the device only reacts to host edges, it never starts one
    always_comb begin
        st_nxt = st_r;
        // pulses default low so each result lasts exactly one clock
        st_nxt.valid = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.oe = 1'b1; // RL5
        // prescaler write from the register side, independent of the link
        if (prescaler_load_in) begin
            st_nxt.presc = prescaler_data_in;
        end
        if (sel_fall) begin
            // read-back word ready before the first clock edge arrives
            st_nxt.active = 1'b1; // RL13
            st_nxt.tx = read_word_in; // RL19
            st_nxt.sdo = read_word_in[DGRAM_BITS-1]; // RL14
            st_nxt.cnt = '0;
            st_nxt.rx = WORD_RST;
        end else if (st_r.active && !sel_rise) begin
            // mid-frame: only serial clock edges matter here
            if (sck_rise) begin
                st_nxt.rx = {st_r.rx[DGRAM_BITS-2:0], sdi_bit}; // RL7 RL8 RL14
                // saturate so a runaway host cannot wrap the count to a legal value
                if (st_r.cnt != DGRAM_CNT) begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            // the fall before the first rise must not skip the msb
            if (sck_fall && st_r.cnt != '0) begin
                st_nxt.tx = {st_r.tx[DGRAM_BITS-2:0], 1'b0}; // RL10
                st_nxt.sdo = st_r.tx[DGRAM_BITS-2]; // RL12
            end
        end else if (sel_rise && st_r.active) begin
            // frame closes: decide between execute and drop
            st_nxt.active = 1'b0;
            // a short frame is dropped rather than executed half-formed
            if (st_r.cnt == DGRAM_CNT) begin
                st_nxt.hold = st_r.rx; // RL9 RL6
                st_nxt.valid = 1'b1;
                st_nxt.is_read = (st_r.rx[RW_POS] == RW_READ); // RL17
            end else begin
                st_nxt.err = 1'b1; // RL6
            end
            st_nxt.sdo = irq_n_in; // RL4
        end else if (!st_r.active) begin
            // idle: track the interrupt level every clock
            st_nxt.sdo = irq_n_in; // RL4
        end
    end

    // power-on reset is the only reset source
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= '0; // RL1 RL3
            // pin idles high in reset: no interrupt pending
            st_r.sdo <= 1'b1;
            st_r.oe <= 1'b1; // RL5
            // besides the pin level and its enable, the prescaler is the only field with a non-zero reset value
            st_r.presc <= PRESC_RST; // RL3
        end else begin
            st_r <= st_nxt;
        end
    end

    // all outputs straight from state flops; the enable is a flop rather than
    // a constant tie so the pin driver sees a registered level like the data
    assign serial_out_irq_pin_out = st_r.sdo;
    assign serial_out_irq_pin_oe_out = st_r.oe;
    assign hold_word_out = st_r.hold;
    assign hold_valid_out = st_r.valid;
    assign hold_is_read_out = st_r.is_read;
    assign frame_error_out = st_r.err;
    assign step_clock_prescaler_out = st_r.presc;
endmodule
`default_nettype wire

// ### hsdp_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hsdp_port_properties
    import hsdp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // serial pins
    input wire logic host_select_n_in,
    input wire logic host_serial_clock_in,
    input wire logic serial_out_irq_pin_out,
    input wire logic serial_out_irq_pin_oe_out,
    // internal side
    input wire logic irq_n_in,
    input wire logic prescaler_load_in,
    input wire logic [PRESC_W-1:0] prescaler_data_in,
    input wire logic [DGRAM_BITS-1:0] hold_word_out,
    input wire logic hold_valid_out,
    input wire logic hold_is_read_out,
    input wire logic frame_error_out,
    input wire logic [PRESC_W-1:0] step_clock_prescaler_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // a frame closes on select rise and ends in exactly one result pulse
    sequence sel_rise_s; $rose(host_select_n_in); endsequence
    sequence result_s; hold_valid_out || frame_error_out; endsequence
    oe_always_a: assert property (serial_out_irq_pin_oe_out) else $error("pin undriven");
    idle_irq_a: assert property (host_select_n_in[*5] |-> serial_out_irq_pin_out == $past(irq_n_in))
        else $error("idle pin not irq");
    frame_close_a: assert property (sel_rise_s |-> ##[2:4] result_s) else $error("no frame result");
    idle_quiet_a: assert property (host_select_n_in[*6] |-> !result_s) else $error("pulse while idle");
    word_hold_a: assert property (!hold_valid_out |-> $stable(hold_word_out)) else $error("hold moved");
    rw_flag_a: assert property (hold_valid_out |-> hold_is_read_out == hold_word_out[RW_POS])
        else $error("rw flag wrong");
    presc_load_a: assert property (prescaler_load_in |=> step_clock_prescaler_out == $past(prescaler_data_in))
        else $error("prescaler not loaded");
    sdo_steady_a: assert property ($rose(host_serial_clock_in) && !host_select_n_in |=>
        $stable(serial_out_irq_pin_out)[*3]) else $error("pin moved in high phase");
    err_excl_a: assert property (!(hold_valid_out && frame_error_out)) else $error("valid with error");
endmodule
`default_nettype wire

// ### hsdp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hsdp_sync
    import hsdp_pkg::*;
#(
    parameter int unsigned WIDTH = PIN_N
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // asynchronous pins
    input wire logic [WIDTH-1:0] pins_in,
    // synchronised view
    hsdp_pins_if.sync pins
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] agreed;
    } hsdp_sync_s;

    hsdp_sync_s st_r;
    hsdp_sync_s st_nxt;
    logic [WIDTH-1:0] agree;

    // a new level is accepted only where stages two and three hold the same value
    assign agree = ~(st_r.s2 ^ st_r.s3);

    initial begin
        if (WIDTH != PIN_N) $error("hsdp_sync width must match pin count");
    end

    // three stages; s1 feeds only s2 so a metastable sample never reaches logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins_in; // RL18
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.agreed = (agree & st_r.s3) | (~agree & st_r.agreed);
    end

    // idle bus is high on select and clock, so reset to ones avoids a false edge
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // an edge counts once stages two and three agree on a level the agreed copy lacks
    assign pins.level = (agree & st_r.s3) | (~agree & st_r.agreed);
    assign pins.prior = st_r.agreed;
endmodule
`default_nettype wire
